/* File: core/pmc_pkg.sv */
// Package of constants and types for the power mode controller
package pmc_pkg;
  // Active mode selection codes
  typedef enum logic [2:0] {
    PMC_ACT_SIX_AXIS = 3'h0,
    PMC_ACT_ACCEL    = 3'h1,
    PMC_ACT_GYRO     = 3'h2,
    PMC_ACT_CPU      = 3'h3,
    PMC_ACT_VECTOR   = 3'h4,
    PMC_ACT_LEGACY   = 3'h5
  } pmc_active_t;
  // Sleep level requests
  typedef enum logic [1:0] {
    PMC_SLP_NONE  = 2'h0,
    PMC_SLP_LIGHT = 2'h1,
    PMC_SLP_DEEP  = 2'h2,
    PMC_SLP_DOWN  = 2'h3
  } pmc_sleep_t;
  // Element drive levels for processors and sensors
  typedef enum logic [1:0] {
    PMC_EL_OFF  = 2'h0,
    PMC_EL_DUTY = 2'h1,
    PMC_EL_ON   = 2'h2
  } pmc_elem_t;
  // Restart and restore durations
  localparam int PMC_RESTART_NS = 800;
  localparam int PMC_RESTORE_NS = 80;
  localparam int PMC_CLK_NS = 8;
  localparam int PMC_RESTART_CYC = (PMC_RESTART_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
  localparam int PMC_RESTORE_CYC = (PMC_RESTORE_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
  localparam logic [7:0] PMC_CNT_RESET = 8'h00;
  localparam pmc_active_t PMC_MODE_RESET = PMC_ACT_SIX_AXIS;
endpackage

/* File: core/pmc_ctrl.sv */
// Power mode sequencer with element gating and supply selection
`timescale 1ns/1ps
module pmc_ctrl
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Host request port
  input wire logic req_valid,
  input wire pmc_sleep_t req_sleep,
  input wire pmc_active_t req_mode,
  input wire logic req_low_noise,
  output logic req_ready,
  output logic req_reject,
  // Wake sources from outside the clock domain
  input wire logic ext_wake_pin,
  input wire logic slow_rc_tick,
  // Flash supply setting
  input wire logic flash_ext_supply,
  // Power and clock controls
  output logic digital_power_on,
  output logic rom_flash_power_on,
  output logic rc_osc_on,
  output logic state_clear,
  output logic ext_supply_sel,
  // Element controls
  output pmc_elem_t general_cpu_ctl,
  output pmc_elem_t vector_coprocessor_ctl,
  output pmc_elem_t legacy_motion_coprocessor_ctl,
  output pmc_elem_t gyro_ctl,
  output pmc_elem_t accel_ctl,
  output logic gyro_low_noise,
  output logic accel_low_noise,
  // Status
  output logic active,
  output pmc_sleep_t sleep_state
);
  // ==========================================================
  // Input synchronisers
  logic wake_s1_q, wake_s2_q, tick_s1_q, tick_s2_q, tick_s3_q;
  // Two stages before use; tick edge taken from second and third stage only
  always_ff @(posedge clk_sys) begin
    wake_s1_q <= ext_wake_pin;
    wake_s2_q <= wake_s1_q;
    tick_s1_q <= slow_rc_tick;
    tick_s2_q <= tick_s1_q;
    tick_s3_q <= tick_s2_q;
  end
  logic slow_tick;
  assign slow_tick = tick_s2_q & ~tick_s3_q;
  // ==========================================================
  // Sequencer
  typedef enum {ST_ACTIVE, ST_SLEEP, ST_RESTORE, ST_RESTART} pmc_state_t;
  pmc_state_t st_q;
  pmc_sleep_t lvl_q;
  logic [7:0] cnt_q;
  logic wake_ev;
  // Periodic tick only wakes light sleep; external pin or host wake all levels
  assign wake_ev = wake_s2_q | req_valid | (slow_tick & (lvl_q == PMC_SLP_LIGHT));
  // Requests are only served in active; a host request during sleep wakes first
  assign req_ready = (st_q == ST_ACTIVE);
  assign req_reject = 1'b0;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= ST_RESTART;
      lvl_q <= PMC_SLP_NONE;
      cnt_q <= PMC_CNT_RESET;
    end else begin
      case (st_q)
        ST_ACTIVE: begin
          // Only active reaches a sleep level, so sleep-to-sleep never occurs
          if (req_valid && req_sleep != PMC_SLP_NONE) begin
            st_q <= ST_SLEEP;
            lvl_q <= req_sleep;
          end
        end
        ST_SLEEP: begin
          if (wake_ev) begin
            cnt_q <= PMC_CNT_RESET;
            // Power down lost everything, so it restarts rather than restores
            st_q <= (lvl_q == PMC_SLP_DOWN) ? ST_RESTART : ST_RESTORE;
          end
        end
        ST_RESTORE: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(PMC_RESTORE_CYC - 1)) begin
            st_q <= ST_ACTIVE;
            lvl_q <= PMC_SLP_NONE;
          end
        end
        default: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(PMC_RESTART_CYC - 1)) begin
            st_q <= ST_ACTIVE;
            lvl_q <= PMC_SLP_NONE;
            cnt_q <= PMC_CNT_RESET;
          end
        end
      endcase
    end
  end
  // ==========================================================
  // Active mode selection, lost in power down
  pmc_active_t mode_q;
  logic ln_q;
  always_ff @(posedge clk_sys) begin
    if (reset || state_clear) begin
      mode_q <= PMC_MODE_RESET;
      ln_q <= 1'b0;
    end else if (st_q == ST_ACTIVE && req_valid && req_sleep == PMC_SLP_NONE) begin
      mode_q <= req_mode;
      ln_q <= req_low_noise;
    end
  end
  // Supply source latched from Flash on every cycle in restart, after reset or power down
  always_ff @(posedge clk_sys) begin
    if (st_q == ST_RESTART) begin
      ext_supply_sel <= flash_ext_supply;
    end
  end
  // ==========================================================
  // Power domain controls
  logic in_sleep;
  assign in_sleep = (st_q == ST_SLEEP);
  assign digital_power_on = !(in_sleep && lvl_q == PMC_SLP_DOWN);
  assign rom_flash_power_on = !(in_sleep && lvl_q != PMC_SLP_LIGHT);
  assign rc_osc_on = !in_sleep;
  assign state_clear = in_sleep && lvl_q == PMC_SLP_DOWN;
  assign active = (st_q == ST_ACTIVE);
  assign sleep_state = in_sleep ? lvl_q : PMC_SLP_NONE;
  // ==========================================================
  // Element table; processors duty cycle in sensor modes
  pmc_elem_t sens_lvl;
  assign sens_lvl = ln_q ? PMC_EL_ON : PMC_EL_DUTY;
  always_comb begin
    general_cpu_ctl = PMC_EL_OFF;
    vector_coprocessor_ctl = PMC_EL_OFF;
    legacy_motion_coprocessor_ctl = PMC_EL_OFF;
    gyro_ctl = PMC_EL_OFF;
    accel_ctl = PMC_EL_OFF;
    if (st_q == ST_ACTIVE) begin
      case (mode_q)
        PMC_ACT_SIX_AXIS: begin
          general_cpu_ctl = PMC_EL_DUTY;
          vector_coprocessor_ctl = PMC_EL_DUTY;
          legacy_motion_coprocessor_ctl = PMC_EL_DUTY;
          gyro_ctl = sens_lvl;
          accel_ctl = sens_lvl;
        end
        PMC_ACT_ACCEL: begin
          general_cpu_ctl = PMC_EL_DUTY;
          vector_coprocessor_ctl = PMC_EL_DUTY;
          legacy_motion_coprocessor_ctl = PMC_EL_DUTY;
          accel_ctl = sens_lvl;
        end
        PMC_ACT_GYRO: begin
          general_cpu_ctl = PMC_EL_DUTY;
          vector_coprocessor_ctl = PMC_EL_DUTY;
          legacy_motion_coprocessor_ctl = PMC_EL_DUTY;
          gyro_ctl = sens_lvl;
        end
        PMC_ACT_CPU: general_cpu_ctl = PMC_EL_ON;
        PMC_ACT_VECTOR: vector_coprocessor_ctl = PMC_EL_ON;
        default: legacy_motion_coprocessor_ctl = PMC_EL_ON;
      endcase
    end
  end
  assign gyro_low_noise = (gyro_ctl == PMC_EL_ON);
  assign accel_low_noise = (accel_ctl == PMC_EL_ON);
  // ==========================================================
  // Checks
  sleep_entry_a: assert property (@(posedge clk_sys) disable iff (reset)
    active && req_valid && req_sleep != PMC_SLP_NONE |=> in_sleep && lvl_q == $past(req_sleep))
    else $error("sleep entry missed");
  sleep_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    in_sleep && !wake_ev |=> in_sleep && $stable(lvl_q)) else $error("sleep level changed");
  down_power_a: assert property (@(posedge clk_sys) disable iff (reset)
    in_sleep && lvl_q == PMC_SLP_DOWN |-> !digital_power_on && state_clear) else $error("power down leak");
  deep_power_a: assert property (@(posedge clk_sys) disable iff (reset)
    in_sleep && lvl_q == PMC_SLP_DEEP |-> digital_power_on && !rom_flash_power_on && !rc_osc_on)
    else $error("deep sleep power wrong");
  light_power_a: assert property (@(posedge clk_sys) disable iff (reset)
    in_sleep && lvl_q == PMC_SLP_LIGHT |-> rom_flash_power_on && !rc_osc_on && gyro_ctl == PMC_EL_OFF)
    else $error("sleep power wrong");
  single_proc_a: assert property (@(posedge clk_sys) disable iff (reset)
    active && mode_q >= PMC_ACT_CPU |-> gyro_ctl == PMC_EL_OFF && accel_ctl == PMC_EL_OFF)
    else $error("sensor on in processor mode");
  duty_default_a: assert property (@(posedge clk_sys) disable iff (reset)
    active && !ln_q && mode_q == PMC_ACT_SIX_AXIS |-> gyro_ctl == PMC_EL_DUTY && accel_ctl == PMC_EL_DUTY)
    else $error("sensor not duty cycled");
  restore_time_a: assert property (@(posedge clk_sys) disable iff (reset)
    in_sleep && wake_ev && lvl_q != PMC_SLP_DOWN |=> !active [*8] ##[1:4] active)
    else $error("restore timing wrong");
  wake_req_a: assert property (@(posedge clk_sys) disable iff (reset)
    in_sleep && req_valid |-> ##[1:110] active) else $error("host request not served");
  // Supply source is fixed once running; only a restart may pick it up again
  supply_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    active && $past(active) |-> $stable(ext_supply_sel)) else $error("supply source changed");
  // A slow tick in light sleep must start the wake on the very next edge
  tick_wake_a: assert property (@(posedge clk_sys) disable iff (reset)
    in_sleep && lvl_q == PMC_SLP_LIGHT && slow_tick |=> !in_sleep) else $error("slow tick did not wake");
  cov_deep_c: cover property (@(posedge clk_sys) in_sleep && lvl_q == PMC_SLP_DEEP ##[1:50] active);
  cov_down_c: cover property (@(posedge clk_sys) state_clear ##[1:200] active);
  cov_tick_c: cover property (@(posedge clk_sys) in_sleep && slow_tick);
  cov_light_c: cover property (@(posedge clk_sys) in_sleep && lvl_q == PMC_SLP_LIGHT ##[1:50] active);
endmodule

/* File: sim/pmc_host.sv */
// Host processor model that issues power mode requests
`timescale 1ns/1ps
module pmc_host
  import pmc_pkg::*;
(
  // Bench control
  input wire logic clk_sys,
  input wire logic go,
  input wire pmc_sleep_t slp,
  input wire pmc_active_t mode,
  input wire logic ln,
  output logic done,
  // Request port
  input wire logic req_ready,
  output logic req_valid,
  output pmc_sleep_t req_sleep,
  output pmc_active_t req_mode,
  output logic req_low_noise
);
  // Idle values at time zero
  initial begin
    req_valid = 1'b0;
    req_sleep = PMC_SLP_NONE;
    req_mode = PMC_ACT_SIX_AXIS;
    req_low_noise = 1'b0;
    done = 1'b0;
  end
  // Taken only where ready is sampled high with valid
  always @(posedge clk_sys) done <= req_valid && req_ready;
  // Held until taken in any mode; released fields go inverted so stale data never passes
  always @(negedge clk_sys) begin
    if (done) begin
      req_valid <= 1'b0;
      req_sleep <= pmc_sleep_t'(~req_sleep);
      req_mode <= pmc_active_t'(~req_mode);
      req_low_noise <= ~req_low_noise;
    end else if (go && !req_valid) begin
      req_valid <= 1'b1;
      req_sleep <= slp;
      req_mode <= mode;
      req_low_noise <= ln;
    end
  end
endmodule

/* File: sim/tb_top.sv */
// Self-checking testbench of the power mode controller
`timescale 1ns/1ps
module tb_top;
  import pmc_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, go = 1'b0, ln = 1'b0, done, pin = 1'b0, tick = 1'b0, flash = 1'b1;
  logic req_valid, req_low_noise, req_ready, req_reject, dpw, rfp, rco, sclr, esel, act, gln, aln;
  pmc_sleep_t slp = PMC_SLP_NONE, req_sleep, sst;
  pmc_active_t mode = PMC_ACT_SIX_AXIS, req_mode;
  pmc_elem_t cpu, vec, leg, gyr, acc;
  int err_total = 0, samples_checked = 0;
  // Clock of 8 ns
  initial forever #4 clk_sys = ~clk_sys;
  pmc_host i_host (.clk_sys(clk_sys), .go(go), .slp(slp), .mode(mode), .ln(ln), .done(done),
    .req_ready(req_ready), .req_valid(req_valid), .req_sleep(req_sleep), .req_mode(req_mode),
    .req_low_noise(req_low_noise));
  pmc_ctrl i_dut (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req_sleep(req_sleep),
    .req_mode(req_mode), .req_low_noise(req_low_noise), .req_ready(req_ready), .req_reject(req_reject),
    .ext_wake_pin(pin), .slow_rc_tick(tick), .flash_ext_supply(flash), .digital_power_on(dpw),
    .rom_flash_power_on(rfp), .rc_osc_on(rco), .state_clear(sclr), .ext_supply_sel(esel),
    .general_cpu_ctl(cpu), .vector_coprocessor_ctl(vec), .legacy_motion_coprocessor_ctl(leg),
    .gyro_ctl(gyr), .accel_ctl(acc), .gyro_low_noise(gln), .accel_low_noise(aln), .active(act),
    .sleep_state(sst));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Element drives expected per mode; processors duty cycle in the sensor modes
  function automatic logic [9:0] exp_el(input pmc_active_t m, input logic n);
    logic [1:0] s;
    s = n ? 2'h2 : 2'h1;
    case (m)
      PMC_ACT_SIX_AXIS: exp_el = {6'h15, s, s};
      PMC_ACT_ACCEL: exp_el = {6'h15, 2'h0, s};
      PMC_ACT_GYRO: exp_el = {6'h15, s, 2'h0};
      PMC_ACT_CPU: exp_el = 10'h200;
      PMC_ACT_VECTOR: exp_el = 10'h080;
      default: exp_el = 10'h020;
    endcase
  endfunction
  // One host request, bounded wait for the take
  task automatic req(input pmc_sleep_t s, input pmc_active_t m, input logic n);
    int i;
    @(negedge clk_sys);
    slp <= s;
    mode <= m;
    ln <= n;
    go <= 1'b1;
    @(negedge clk_sys);
    go <= 1'b0;
    for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk_sys);
    if (i == 300) begin
      err_total++;
      conclude();
    end
    @(negedge clk_sys);
  endtask
  // Bounded wait until active
  task automatic wait_act(input int lim);
    int i;
    for (i = 0; i < lim && act !== 1'b1; i++) @(negedge clk_sys);
    chk(act, 12'h1);
    if (act !== 1'b1) conclude();
  endtask
  function automatic logic [11:0] el_now();
    el_now = {gln, aln, cpu, vec, leg, gyr, acc};
  endfunction
  // Restart after reset: inactive, then six-axis duty, supply chosen from Flash
  task automatic t_reset();
    repeat (50) @(negedge clk_sys);
    chk({act, req_ready}, 12'h0);
    wait_act(PMC_RESTART_CYC + 20);
    chk({esel, req_reject, sst}, 12'h8);
    chk(el_now(), {2'h0, exp_el(PMC_ACT_SIX_AXIS, 1'b0)});
    $display("test reset done");
  endtask
  // Every active mode with and without low noise
  task automatic t_modes();
    for (int m = 0; m < 6; m++) for (int n = 0; n < 2; n++) begin
      req(PMC_SLP_NONE, pmc_active_t'(m), n[0]);
      chk(el_now(), {{2{n[0] && m < 3}} & {m != 1, m != 2}, exp_el(pmc_active_t'(m), n[0])});
    end
    $display("test modes done");
  endtask
  // Each sleep level, then wake by a host request
  task automatic t_sleep();
    for (int l = 1; l < 4; l++) begin
      req(pmc_sleep_t'(l), PMC_ACT_SIX_AXIS, 1'b0);
      chk({sst, act, rco, rfp, dpw}, {l[1:0], 2'h0, l == 1, l != 3});
      chk({sclr, el_now()}, {l == 3, 12'h0});
      req(PMC_SLP_NONE, PMC_ACT_CPU, 1'b0);
      chk({act, el_now()}, {1'b1, 2'h0, exp_el(PMC_ACT_CPU, 1'b0)});
    end
    $display("test sleep done");
  endtask
  // Slow tick wakes light sleep only; the pin wakes deep sleep
  task automatic t_wake();
    req(PMC_SLP_DEEP, PMC_ACT_SIX_AXIS, 1'b0);
    tick <= 1'b1;
    repeat (20) @(negedge clk_sys);
    tick <= 1'b0;
    chk({act, sst}, 12'h2);
    pin <= 1'b1;
    wait_act(PMC_RESTORE_CYC + 20);
    pin <= 1'b0;
    req(PMC_SLP_LIGHT, PMC_ACT_SIX_AXIS, 1'b0);
    repeat (5) @(negedge clk_sys);
    tick <= 1'b1;
    wait_act(PMC_RESTORE_CYC + 20);
    tick <= 1'b0;
    $display("test wake done");
  endtask
  // Mid-run reset with the Flash setting flipped: restart, internal supply, mode back to default
  task automatic t_supply();
    req(PMC_SLP_NONE, PMC_ACT_GYRO, 1'b1);
    flash <= 1'b0;
    reset <= 1'b1;
    repeat (10) @(negedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk({act, req_ready}, 16'h0);
    wait_act(PMC_RESTART_CYC + 20);
    chk({esel, req_reject, sst}, 16'h0);
    chk(el_now(), {2'h0, exp_el(PMC_ACT_SIX_AXIS, 1'b0)});
    $display("test supply done");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_modes();
    t_sleep();
    t_wake();
    t_supply();
    conclude();
  end
endmodule
